/* hdl/xcbt_top.sv */
/*
  Board-level connectivity test mode: entry/exit sampled at the release of the system reset pin,
  pin functions isolated while active, parity of all chain inputs driven on the event pin.
  Assumes rst is the main-supply power-on reset, synchronous to clock, and that the core logic
  behind the pins runs on the same clock.
*/
`timescale 1ns/1ns
`include "xcbt_regs.svh"

module xcbt_top (
  input wire logic clock, // System clock, 125 MHz
  input wire logic rst, // Main-supply power-on reset, active high
  input wire logic system_reset_n_pin, // System reset pin, active low
  input wire logic lpc_frame_n_pin, // Frame pin level
  input wire logic lpc_addr_data_bit0_pin, // Address/data bit 0 pin level
  output logic lpc_addr_data_bit0_out, // Address/data bit 0 drive level
  output logic lpc_addr_data_bit0_oe, // Address/data bit 0 drive enable
  input wire logic [`XCBT_OTHER_PINS-1:0] other_pin_in, // Remaining chain pin levels
  output logic [`XCBT_OTHER_PINS-1:0] other_pin_out, // Remaining pin drive levels
  output logic [`XCBT_OTHER_PINS-1:0] other_pin_oe, // Remaining pin drive enables
  output logic pm_event_n_out, // Event pin level
  output logic pm_event_n_oe, // Event pin drive enable
  output xcbt_pkg::xcbt_pins_s core_pin_in, // Pin levels towards the core
  output logic core_system_reset_n, // Synchronised system reset towards the core
  input wire logic core_lad0_out, // Core address/data bit 0 level
  input wire logic core_lad0_oe, // Core address/data bit 0 enable
  input wire logic [`XCBT_OTHER_PINS-1:0] core_pin_out, // Core drive levels
  input wire logic [`XCBT_OTHER_PINS-1:0] core_pin_oe, // Core drive enables
  input wire xcbt_pkg::xcbt_drive_s core_pme, // Core event pin level and enable
  output logic test_mode // Chain test mode active
);
  import xcbt_pkg::*;

  localparam int NPINS = `XCBT_OTHER_PINS + 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Crystal, supply and event pins never reach this vector
  xcbt_pins_s pins_raw;
  xcbt_pins_s pins_sync;
  logic sysrst_sync;
  logic sysrst_prev;
  logic sysrst_rise;

  assign pins_raw.frame_n = lpc_frame_n_pin;
  assign pins_raw.lad0 = lpc_addr_data_bit0_pin;
  assign pins_raw.other = other_pin_in;

  xcbt_sync #(
    .WIDTH(NPINS),
    .RST_VAL({NPINS{1'b1}})
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .d(pins_raw),
    .q(pins_sync)
  );

  xcbt_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clock(clock),
    .rst(rst),
    .d(system_reset_n_pin),
    .q(sysrst_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode flag

  xcbt_mode_e mode;

  always_ff @(posedge clock)
  begin
    if (rst)
      sysrst_prev <= 1'h0;
    else
      sysrst_prev <= sysrst_sync;
  end

  assign sysrst_rise = sysrst_sync & ~sysrst_prev;

  // Sampled once per release, so pin activity in mode cannot disturb the flag
  always_ff @(posedge clock)
  begin
    if (rst)
      mode <= XCBT_NORMAL;
    else if (sysrst_rise)
    begin
      case ({pins_sync.frame_n, pins_sync.lad0})
        2'b00: mode <= XCBT_CHAIN;
        default: mode <= XCBT_NORMAL;
      endcase
    end
  end

  assign test_mode = (mode == XCBT_CHAIN);

  ////////////////////////////////////////////////////////////////////////////////
  // Chain

  logic chain_out;

  // Request pins feed the chain like any other input
  xcbt_parity u_parity (
    .clock(clock),
    .rst(rst),
    .pins(pins_sync),
    .parity(chain_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer

  // Event pin: chain result in mode, core function otherwise
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pm_event_n_out <= `XCBT_PME_LEVEL_RST;
      pm_event_n_oe <= `XCBT_PME_OE_RST;
    end
    else
    begin
      case (mode)
        XCBT_CHAIN:
        begin
          pm_event_n_out <= chain_out;
          pm_event_n_oe <= 1'h1;
        end
        default:
        begin
          pm_event_n_out <= core_pme.level;
          pm_event_n_oe <= core_pme.oe;
        end
      endcase
    end
  end

  // All other drivers released in mode; data still registered for glitch-free pins
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      other_pin_oe <= {`XCBT_OTHER_PINS{`XCBT_PIN_OE_RST}};
      lpc_addr_data_bit0_oe <= `XCBT_PIN_OE_RST;
    end
    else
    begin
      other_pin_oe <= test_mode ? '0 : core_pin_oe;
      lpc_addr_data_bit0_oe <= test_mode ? 1'h0 : core_lad0_oe;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      other_pin_out <= '0;
      lpc_addr_data_bit0_out <= 1'h0;
    end
    else
    begin
      other_pin_out <= core_pin_out;
      lpc_addr_data_bit0_out <= core_lad0_out;
    end
  end

  // Core sees idle pins in mode, so tester toggling cannot trigger core activity
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_pin_in <= '1;
      core_system_reset_n <= 1'h0;
    end
    else
    begin
      core_pin_in <= test_mode ? '1 : pins_sync;
      core_system_reset_n <= test_mode ? 1'h0 : sysrst_sync;
    end
  end

endmodule // xcbt_top

/* hdl/xcbt_regs.svh */
/*
  Constants for the board-level connectivity chain: pin counts, synchroniser depth and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef XCBT_REGS_SVH
`define XCBT_REGS_SVH

// Chain inputs besides the two entry-request pins
`define XCBT_OTHER_PINS 78
// Flip-flops in each pin synchroniser
`define XCBT_SYNC_STAGES 2
// Test-mode flag after supply power-on reset
`define XCBT_MODE_RST 1'h0
// Event pin level and enable after reset (released, not driven)
`define XCBT_PME_LEVEL_RST 1'h1
`define XCBT_PME_OE_RST 1'h0
// Pin output enables after reset
`define XCBT_PIN_OE_RST 1'h0

`endif

/* hdl/xcbt_pkg.sv */
/*
  Types shared by the connectivity chain modules.
  Assumes xcbt_regs.svh is on the include path.
*/
`include "xcbt_regs.svh"

package xcbt_pkg;

  // Level and enable of one driven pin
  typedef struct packed {
    logic level;
    logic oe;
  } xcbt_drive_s;

  // Every chain input pin, gathered in one carrier
  typedef struct packed {
    logic frame_n;
    logic lad0;
    logic [`XCBT_OTHER_PINS-1:0] other;
  } xcbt_pins_s;

  // Test-mode state of the pin multiplexer
  typedef enum logic [0:0] {
    XCBT_NORMAL = 1'b0,
    XCBT_CHAIN = 1'b1
  } xcbt_mode_e;

endpackage

/* hdl/xcbt_sync.sv */
/*
  Multi-bit two-flop synchroniser for pins arriving from outside the clock domain.
  Assumes each bit is independent; no bus coherence is promised across bits.
*/
`timescale 1ns/1ns

module xcbt_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] d, // Asynchronous pin levels
  output logic [WIDTH-1:0] q // Synchronised levels
);
  import xcbt_pkg::*;

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // xcbt_sync

/* hdl/xcbt_parity.sv */
/*
  Registered parity of all chain inputs.
  Assumes inputs are already synchronised to clock.
*/
`timescale 1ns/1ns

module xcbt_parity (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire xcbt_pkg::xcbt_pins_s pins, // Synchronised chain inputs
  output logic parity // One when an odd number of inputs are high
);
  import xcbt_pkg::*;

  function automatic logic chain_parity(input xcbt_pins_s p);
    chain_parity = ^{p.frame_n, p.lad0, p.other};
  endfunction

  // Any single input flipping flips the result; all low gives low
  always_ff @(posedge clock)
  begin
    if (rst)
      parity <= 1'h0;
    else
      parity <= chain_parity(pins);
  end

endmodule // xcbt_parity

/* verification/xcbt_chk.sv */
/*
  Assertions on the chain block ports.
  Assumes bind from the bench top.
*/
`timescale 1ns/1ns
`include "xcbt_regs.svh"
module xcbt_chk (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic system_reset_n_pin, // Reset pin
  input wire logic lpc_frame_n_pin, // Frame pin
  input wire logic lpc_addr_data_bit0_pin, // Bit0 pin
  input wire logic [`XCBT_OTHER_PINS-1:0] other_pin_in, // Other pins
  input wire logic lpc_addr_data_bit0_oe, // Bit0 enable
  input wire logic [`XCBT_OTHER_PINS-1:0] other_pin_oe, // Other enables
  input wire logic pm_event_n_out, // Event level
  input wire logic pm_event_n_oe, // Event enable
  input wire xcbt_pkg::xcbt_drive_s core_pme, // Core event
  input wire logic test_mode // Mode flag
);
  import xcbt_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  mode_hold_a: assert property (
    !$past(rst) && $changed(test_mode) |-> $past(system_reset_n_pin, 3) && !$past(system_reset_n_pin, 4))
    else $error("mode flag moved without a release");
  enter_a: assert property (
    $rose(system_reset_n_pin) && !lpc_frame_n_pin && !lpc_addr_data_bit0_pin |-> ##4 test_mode)
    else $error("mode not entered");
  exit_a: assert property (
    $rose(system_reset_n_pin) && (lpc_frame_n_pin || lpc_addr_data_bit0_pin) |-> ##4 !test_mode)
    else $error("mode not left");
  por_clear_a: assert property (
    disable iff (1'b0) rst |=> !test_mode && !pm_event_n_oe)
    else $error("reset left mode set");
  pin_isolate_a: assert property (
    !$past(rst) && $past(test_mode) |-> !lpc_addr_data_bit0_oe && other_pin_oe == '0)
    else $error("pin driven in test mode");
  event_drive_a: assert property (
    !$past(rst) && $past(test_mode) |-> pm_event_n_oe)
    else $error("event pin not driven");
  chain_parity_a: assert property (
    !$past(rst) && $past(test_mode) |->
    pm_event_n_out == (^$past(other_pin_in, 4) ^ $past(lpc_frame_n_pin, 4) ^ $past(lpc_addr_data_bit0_pin, 4)))
    else $error("chain output wrong");
  normal_event_a: assert property (
    !$past(rst) && !$past(test_mode) |-> pm_event_n_out == $past(core_pme.level) && pm_event_n_oe == $past(core_pme.oe))
    else $error("event pin not from core");
endmodule // xcbt_chk

/* verification/xcbt_fixture.sv */
/*
  Board test fixture: drives the chain pins, watches the event pin.
  Assumes the bench calls its tasks.
*/
`timescale 1ns/1ns
module xcbt_fixture (
  input wire logic clock, // Clock
  input wire logic pme_out, // Event level
  input wire logic pme_oe, // Event enable
  output logic reset_n, // Reset pin
  output xcbt_pkg::xcbt_pins_s pins, // Chain pins
  output logic pme_seen // Event wire
);
  import xcbt_pkg::*;
  initial
  begin
    reset_n = 1'b0;
    pins = '0;
  end
  // Released event pin rests at its pull-up
  assign pme_seen = pme_oe ? pme_out : 1'b1;
  task put(input xcbt_pins_s v);
    @(posedge clock);
    #1 pins = v;
  endtask
  // Request pins settle 4 cycles before the rise and hold after it
  task release_rst(input logic f, input logic l);
    @(posedge clock);
    #1 reset_n = 1'b0;
    pins.frame_n = f;
    pins.lad0 = l;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge clock);
    #1;
  endtask
  // Pull the reset pin low again, request pins untouched
  task drop_rst;
    @(posedge clock);
    #1 reset_n = 1'b0;
  endtask
endmodule // xcbt_fixture

/* verification/xcbt_top_bench.sv */
/*
  Bench for the chain block.
  Assumes the fixture and checker are compiled first.
*/
`timescale 1ns/1ns
module xcbt_top_bench;
  import xcbt_pkg::*;
  logic clock, rst, lad0_o, lad0_oe, pme_o, pme_oe, pme_seen, fx_rst_n, core_lad0_oe, test_mode, csr;
  logic [77:0] oth_o, oth_oe, core_pin_oe;
  xcbt_pins_s fx_pins, p, cpi;
  xcbt_drive_s core_pme;
  int bad_count, compares, cycles;
  xcbt_fixture fx (.clock(clock), .pme_out(pme_o), .pme_oe(pme_oe), .reset_n(fx_rst_n), .pins(fx_pins),
    .pme_seen(pme_seen));
  xcbt_top dut (.clock(clock), .rst(rst), .system_reset_n_pin(fx_rst_n), .lpc_frame_n_pin(fx_pins.frame_n),
    .lpc_addr_data_bit0_pin(lad0_oe ? lad0_o : fx_pins.lad0), .lpc_addr_data_bit0_out(lad0_o),
    .lpc_addr_data_bit0_oe(lad0_oe), .other_pin_in((oth_oe & oth_o) | (~oth_oe & fx_pins.other)),
    .other_pin_out(oth_o), .other_pin_oe(oth_oe), .pm_event_n_out(pme_o), .pm_event_n_oe(pme_oe),
    .core_pin_in(cpi), .core_system_reset_n(csr), .core_lad0_out(1'b1), .core_lad0_oe(core_lad0_oe),
    .core_pin_out('1), .core_pin_oe(core_pin_oe), .core_pme(core_pme), .test_mode(test_mode));
  task chk(input string n, input logic [79:0] s, input logic [79:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task step(input logic e);
    fx.put(p);
    repeat (6) @(posedge clock);
    #1 chk("chain", pme_seen, e);
  endtask
  task t_modes;
    for (int i = 0; i < 4; i++)
    begin
      fx.release_rst(i[1], i[0]);
      chk("mode", test_mode, i == 0);
    end
  endtask
  task t_walk;
    fx.release_rst(1'b0, 1'b0);
    chk("all low", pme_seen, 0);
    core_pin_oe = '1;
    core_lad0_oe = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("isolate", {lad0_oe, oth_oe}, 0);
    chk("core pins", cpi, '1);
    chk("core reset", csr, 0);
    core_pin_oe = '0;
    core_lad0_oe = 1'b0;
    p = '0;
    for (int k = 79; k >= 0; k--)
    begin
      p[k] = 1'b1;
      step(k[0]);
    end
    // Lowered from the other end, as the bench loop walks back up the pins
    for (int k = 0; k < 80; k++)
    begin
      p[k] = 1'b0;
      step(~k[0]);
    end
  endtask
  task t_exit;
    fx.release_rst(1'b1, 1'b0);
    chk("exit", test_mode, 0);
    // One pin high: a live chain would read high, the core asks for low
    p = '0;
    p[5] = 1'b1;
    step(1'b0);
    chk("core pass", cpi, p);
    chk("pin out", {lad0_o, oth_o}, {79{1'b1}});
    core_pme = '{level: 1'b1, oe: 1'b1};
    p = '0;
    step(1'b1);
  endtask
  task t_por;
    fx.release_rst(1'b0, 1'b0);
    chk("por entry", test_mode, 1);
    fx.drop_rst;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("por", {test_mode, pme_oe}, 0);
    rst = 1'b0;
    repeat (6) @(posedge clock);
    #1 chk("por hold", test_mode, 0);
    chk("por event", pme_seen, 1);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      finish_test;
    end
  end
  initial
  begin
    rst = 1'b1;
    core_lad0_oe = 1'b0;
    core_pin_oe = '0;
    core_pme = '{level: 1'b0, oe: 1'b1};
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    t_modes;
    t_walk;
    t_exit;
    t_por;
    finish_test;
  end
endmodule // xcbt_top_bench
bind xcbt_top xcbt_chk chk (.clock(clock), .rst(rst), .system_reset_n_pin(system_reset_n_pin),
  .lpc_frame_n_pin(lpc_frame_n_pin), .lpc_addr_data_bit0_pin(lpc_addr_data_bit0_pin),
  .other_pin_in(other_pin_in), .lpc_addr_data_bit0_oe(lpc_addr_data_bit0_oe), .other_pin_oe(other_pin_oe),
  .pm_event_n_out(pm_event_n_out), .pm_event_n_oe(pm_event_n_oe), .core_pme(core_pme), .test_mode(test_mode));
